// ===== core/prhp_pkg.sv
// Package for the partial reconfiguration host port.
// Assumes a single 50 MHz core clock and a sampled transfer clock.
// Contract
// [RQ1] Host raises request to begin reconfiguration
// [RQ2] Device raises ready when prepared for data
// [RQ3] Device raises complete when region finished
// [RQ4] Device raises fault on error during reconfiguration
// [RQ5] Host sends sixteen bit bitstream words
// [RQ6] Words sampled on transfer clock edges
// [RQ7] Pins act only when pin option selected
// [RQ8] Pin mode uses sixteen bit parallel load
// [RQ9] Internal host repacks data to sixteen bits
// [RQ10] Exactly one host, internal or external
// [RQ11] Host select tied statically by top level
// [RQ12] Words rewrite the region's configuration cells
// [RQ13] Port independent of full configuration scheme
// [RQ14] Host gives four clocks before first word
// [RQ15] Request dropped within eight clocks after complete
// [RQ16] Host pauses data and clock together
// [RQ17] Clock runs twenty cycles after complete/fault
// [RQ18] Request held; words only while ready
package prhp_pkg;
  // ==========================================================
  // Sizes and timing
  // ==========================================================
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned LEAD_CLOCKS = 4;
  localparam int unsigned REQ_DROP_CLOCKS = 8;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 12'h001;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  // Host location codes
  localparam logic HOST_CORE = 1'b0;
  localparam logic HOST_PINS = 1'b1;

  // ==========================================================
  // Types
  // ==========================================================
  // Host side signal group
  typedef struct packed {
    logic request;
    logic clock;
    logic [WORD_W-1:0] word;
  } prhp_host_t;

  // Status returned to the host
  typedef struct packed {
    logic ready;
    logic complete;
    logic fault;
  } prhp_status_t;

  // Controller states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_INIT = 6'h02,
    ST_LEAD = 6'h04,
    ST_LOAD = 6'h08,
    ST_DONE = 6'h10,
    ST_FAIL = 6'h20
  } prhp_state_t;
endpackage

// ===== core/prhp_fifo.sv
// Word FIFO between the transfer-clock sampler and the cell writer.
// Assumes one clock; both sides valid/ready handshakes.
`timescale 1ns/1ns
`default_nettype none
module prhp_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  // ==========================================================
  // Storage and pointers
  // ==========================================================
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } prhp_fifo_st_t;
  prhp_fifo_st_t st, next_st;
  logic [WIDTH-1:0] mem [DEPTH]; // Word array
  logic push, pop;

  assign in_ready = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data = mem[st.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointer values
  always_comb begin
    next_st = st;
    if (flush) begin
      next_st = '0;
    end else begin
      if (push) next_st.wr = st.wr + AW'(1);
      if (pop) next_st.rd = st.rd + AW'(1);
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Register state
  always_ff @(posedge core_clk) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end

  // Write data array
  always_ff @(posedge core_clk) begin
    if (push && !flush) mem[st.wr] <= in_data;
  end
endmodule
`default_nettype wire

// ===== core/prhp_sampler.sv
// Samples the host's pins: two-stage synchronisers and edge find.
// Assumes transfer clock far slower than core_clk (160 ns vs 20 ns).
`timescale 1ns/1ns
`default_nettype none
module prhp_sampler
  import prhp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Raw host pins
  input wire prhp_host_t pins,
  // Synchronised view
  output prhp_host_t synced,
  output logic clk_rise
);
  // ==========================================================
  // Synchroniser state
  // ==========================================================
  typedef struct packed {
    prhp_host_t s1;
    prhp_host_t s2;
    logic clk_last;
  } prhp_smp_st_t;
  prhp_smp_st_t st, next_st;

  // Second stage only feeds logic
  assign synced = st.s2;
  assign clk_rise = st.s2.clock && !st.clk_last; // see [RQ6]

  // Shift the stages
  always_comb begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.clk_last = st.s2.clock;
  end

  // Register stages
  always_ff @(posedge core_clk) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end
endmodule
`default_nettype wire

// ===== core/prhp_port.sv
// Partial reconfiguration host port: handshake, word intake, cell writes.
// Assumes the host supplies the transfer clock; host location strap static.
`timescale 1ns/1ns
`default_nettype none
module prhp_port
  import prhp_pkg::*;
#(
  parameter int unsigned REGION_WORDS = 64,
  parameter int unsigned FIFO_W = WORD_W,
  parameter int unsigned FIFO_D = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host location strap
  input wire logic host_source_select,
  // Pin-side host
  input wire prhp_host_t pin_host,
  // Core-side host
  input wire prhp_host_t core_host,
  // Status to the host
  output prhp_status_t pin_status,
  output prhp_status_t core_status,
  // Configuration cell write port
  output logic cell_we,
  output logic [ADDR_W-1:0] cell_addr,
  output logic [WORD_W-1:0] cell_data,
  input wire logic cell_fault
);
  // ==========================================================
  // Controller state
  // ==========================================================
  typedef struct packed {
    prhp_state_t fsm;
    logic mode_pins;          // Captured host location
    logic [3:0] lead;         // Lead clocks counted
    logic [3:0] hold;         // Clocks since complete
    logic [ADDR_W-1:0] addr;  // Next cell address
    prhp_status_t stat;       // Status flags
    prhp_status_t pin_o;      // Pin status output
    prhp_status_t core_o;     // Core status output
    logic we;
    logic [ADDR_W-1:0] waddr;
    logic [WORD_W-1:0] wdata;
  } prhp_port_st_t;
  prhp_port_st_t st, next_st;

  // ==========================================================
  // Host selection and sampling
  // ==========================================================
  prhp_host_t pin_sync, core_sync, host;
  logic pin_rise, core_rise, rise;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;
  logic [WORD_W-1:0] fifo_out_data;
  logic word_in;

  // Pins are sampled from outside the clock domain
  prhp_sampler u_pin_smp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pins(pin_host),
    .synced(pin_sync),
    .clk_rise(pin_rise)
  );

  // Core host is same domain; find its clock edge directly
  logic core_clk_last;
  always_ff @(posedge core_clk) begin
    if (!rst_n) core_clk_last <= 1'b0;
    else core_clk_last <= core_host.clock;
  end
  assign core_sync = core_host;
  assign core_rise = core_host.clock && !core_clk_last;

  // One host only, chosen by the strap; see [RQ7] [RQ11]
  assign host = st.mode_pins ? pin_sync : core_sync;
  assign rise = st.mode_pins ? pin_rise : core_rise;

  // A word enters on a transfer clock edge while ready; see [RQ6] [RQ8]
  assign word_in = (st.fsm == ST_LOAD) && rise && host.request;
  assign fifo_flush = (st.fsm == ST_IDLE);
  assign fifo_out_ready = (st.fsm == ST_LOAD) || (st.fsm == ST_DONE);

  // Word buffer between intake and cell writes
  prhp_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .in_valid(word_in),
    .in_ready(fifo_in_ready),
    .in_data(host.word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_st = st;
    next_st.we = 1'b0;
    // Cell writes drain the buffer; see [RQ12]
    if (fifo_out_valid && fifo_out_ready) begin
      next_st.we = 1'b1;
      next_st.waddr = st.addr;
      next_st.wdata = fifo_out_data;
      next_st.addr = st.addr + ADDR_ONE;
    end
    unique case (st.fsm)
      // Wait for a request
      ST_IDLE: begin
        next_st.stat = '0;
        next_st.addr = ADDR_ZERO;
        next_st.mode_pins = host_source_select; // see [RQ11]
        if (host.request) begin
          next_st.fsm = ST_INIT; // see [RQ1]
        end
      end
      // Prepare, then raise ready
      ST_INIT: begin
        next_st.lead = CNT_ZERO;
        // Restart from complete must write from the region base again
        next_st.addr = ADDR_ZERO; // see [RQ12] [RQ15]
        next_st.stat.ready = 1'b1; // see [RQ2]
        next_st.fsm = ST_LEAD;
      end
      // Skip the host's lead-in clocks
      ST_LEAD: begin
        if (!host.request) begin
          next_st.fsm = ST_IDLE;
        end else if (rise) begin
          next_st.lead = st.lead + CNT_ONE;
          if (st.lead == 4'(LEAD_CLOCKS - 1)) next_st.fsm = ST_LOAD; // see [RQ14]
        end
      end
      // Accept words until the region is full
      ST_LOAD: begin
        if (cell_fault || (word_in && !fifo_in_ready) || !host.request) begin
          next_st.stat.ready = 1'b0;
          next_st.stat.fault = 1'b1; // see [RQ4] [RQ18]
          next_st.fsm = ST_FAIL;
        end else if (next_st.we && st.addr == ADDR_W'(REGION_WORDS - 1)) begin
          next_st.stat.ready = 1'b0;
          next_st.stat.complete = 1'b1; // see [RQ3]
          next_st.hold = CNT_ZERO;
          next_st.fsm = ST_DONE;
        end
      end
      // Wait for request to drop; restart if it stays
      ST_DONE: begin
        if (!host.request) begin
          next_st.fsm = ST_IDLE;
        end else if (rise) begin
          next_st.hold = st.hold + CNT_ONE;
          if (st.hold == 4'(REQ_DROP_CLOCKS - 1)) begin
            next_st.stat = '0;
            next_st.fsm = ST_INIT; // see [RQ15]
          end
        end
      end
      // Hold fault until request drops
      ST_FAIL: begin
        if (!host.request) next_st.fsm = ST_IDLE;
      end
      default: begin
        next_st.fsm = ST_IDLE;
      end
    endcase
    // Route status to the active host only; see [RQ7] [RQ10]
    next_st.pin_o = next_st.mode_pins ? next_st.stat : '0;
    next_st.core_o = next_st.mode_pins ? '0 : next_st.stat;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.fsm <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from flip-flops
  assign pin_status = st.pin_o;
  assign core_status = st.core_o;
  assign cell_we = st.we;
  assign cell_addr = st.waddr;
  assign cell_data = st.wdata;
endmodule
`default_nettype wire

// ===== bench/prhp_checker.sv
// Assertions on the reconfiguration host port pins.
// Assumes one core_clk domain; bound onto prhp_port.
`timescale 1ns/1ns
`default_nettype none
module prhp_checker
  import prhp_pkg::*;
#(
  parameter int unsigned REGION_WORDS = 64
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host side
  input wire logic host_source_select,
  input wire prhp_host_t pin_host,
  input wire prhp_host_t core_host,
  // Device side
  input wire prhp_status_t pin_status,
  input wire prhp_status_t core_status,
  input wire logic cell_we,
  input wire logic [ADDR_W-1:0] cell_addr,
  input wire logic cell_fault
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Last written cell address
  logic [ADDR_W-1:0] last_addr;
  always_ff @(posedge core_clk) begin
    last_addr <= !rst_n ? ADDR_ZERO : (cell_we ? cell_addr : last_addr);
  end
  a_pin_off: assert property (!host_source_select |-> pin_status == '0)
    else $error("pin status active in core mode");
  a_one_host: assert property (host_source_select |-> core_status == '0)
    else $error("core status active in pin mode");
  a_ready_excl: assert property (!(pin_status.ready && pin_status.complete))
    else $error("ready and complete together");
  a_rdy_pin: assert property ($rose(pin_status.ready) |-> pin_host.request)
    else $error("pin ready without request");
  a_rdy_core: assert property ($rose(core_status.ready) |-> core_host.request)
    else $error("core ready without request");
  a_addr_range: assert property (cell_we |-> cell_addr < REGION_WORDS)
    else $error("cell address beyond region");
  a_addr_step: assert property (cell_we |->
    cell_addr == ADDR_ZERO || cell_addr == last_addr + ADDR_ONE)
    else $error("cell address out of order");
  // Ready with a write just done means a load is running
  a_cell_fault: assert property (core_status.ready && cell_fault && $past(cell_we)
    |-> ##[1:3] core_status.fault)
    else $error("cell fault not reported");
  a_done_clear: assert property ($fell(core_host.request) && core_status.complete
    |-> ##[1:4] !core_status.complete)
    else $error("complete stuck after request drop");
  // Main scenarios reached
  c_pin_done: cover property ($rose(pin_status.complete));
  c_core_fault: cover property ($rose(core_status.fault));
  c_first_write: cover property (cell_we && cell_addr == ADDR_ZERO);
endmodule
bind prhp_port prhp_checker #(.REGION_WORDS(REGION_WORDS)) u_prhp_checker (
  .core_clk(core_clk), .rst_n(rst_n), .host_source_select(host_source_select),
  .pin_host(pin_host), .core_host(core_host), .pin_status(pin_status),
  .core_status(core_status), .cell_we(cell_we), .cell_addr(cell_addr),
  .cell_fault(cell_fault));
`default_nettype wire

// ===== bench/prhp_host_model.sv
// Behavioural reconfiguration host driving one host port.
// Assumes calls start 1 ns after a core_clk edge.
`timescale 1ns/1ns
`default_nettype none
module prhp_host_model
  import prhp_pkg::*;
(
  // Status from the device
  input wire prhp_status_t st,
  // Host lines and restart flag
  output prhp_host_t host,
  output logic rearmed
);
  int k;
  initial begin
    host = '0;
    rearmed = 1'b0;
  end
  // One transfer clock period, word set on the low phase
  task automatic tick(input logic [WORD_W-1:0] w);
    host.word = w;
    #80;
    host.clock = 1'b1;
    #80;
    host.clock = 1'b0;
  endtask
  // Full load; request dropped at hold tick drop_at
  task automatic load(input logic [15:0] base, input int n, input int drop_at,
                      input bit drop_mid);
    rearmed = 1'b0;
    host.request = 1'b1;
    for (k = 0; k < 500 && !st.ready; k++) #20;
    for (k = 0; k < LEAD_CLOCKS; k++) tick(~host.word);
    for (k = 0; k < n; k++) begin
      if (drop_mid && k == 2) host.request = 1'b0;
      tick(base + 16'(k));
    end
    // Clock and data stand still while waiting
    for (k = 0; k < 500 && !(st.complete || st.fault); k++) #20;
    for (k = 0; k < 20; k++) begin
      if (k == drop_at) host.request = 1'b0;
      tick(~host.word);
      if (st.ready) rearmed = 1'b1;
    end
    host.request = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the reconfiguration host port.
// Assumes host models on both host ports.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import prhp_pkg::*;
;
  localparam int RW = 4;
  logic core_clk, rst_n, host_source_select, cell_fault, cell_we;
  prhp_host_t pin_host, core_host;
  prhp_status_t pin_status, core_status;
  logic [ADDR_W-1:0] cell_addr;
  logic [WORD_W-1:0] cell_data;
  logic pin_rearm, core_rearm, done_seen, fault_seen;
  int num_errors, n_tests, cycles, i;
  logic [ADDR_W-1:0] q_addr[$];
  logic [WORD_W-1:0] q_data[$];
  prhp_port #(.REGION_WORDS(RW)) u_prhp_port (
    .core_clk(core_clk), .rst_n(rst_n), .host_source_select(host_source_select),
    .pin_host(pin_host), .core_host(core_host), .pin_status(pin_status),
    .core_status(core_status), .cell_we(cell_we), .cell_addr(cell_addr),
    .cell_data(cell_data), .cell_fault(cell_fault));
  prhp_host_model u_pin_host (.st(pin_status), .host(pin_host), .rearmed(pin_rearm));
  prhp_host_model u_core_host (.st(core_status), .host(core_host), .rearmed(core_rearm));
  always #10 core_clk = ~core_clk;
  // Write log, status flags, timeout
  always @(posedge core_clk) begin
    cycles++;
    if (cell_we) begin
      q_addr.push_back(cell_addr);
      q_data.push_back(cell_data);
    end
    if (pin_status.complete || core_status.complete) done_seen = 1'b1;
    if (pin_status.fault || core_status.fault) fault_seen = 1'b1;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (exp !== got) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic start(input logic sel);
    @(posedge core_clk);
    #1 rst_n = 1'b0;
    host_source_select = sel;
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    done_seen = 1'b0;
    fault_seen = 1'b0;
    q_addr.delete();
    q_data.delete();
  endtask
  task automatic check_load(input logic [15:0] base);
    chk("done", 16'h1, 16'(done_seen));
    chk("fault", 16'h0, 16'(fault_seen));
    chk("writes", 16'(RW), 16'(q_addr.size()));
    for (i = 0; i < RW && i < q_addr.size(); i++) begin
      chk("addr", 16'(i), 16'(q_addr[i]));
      chk("data", base + 16'(i), q_data[i]);
    end
    chk("idle", 16'h0, 16'({pin_status, core_status}));
  endtask
  task automatic t_pin_load();
    start(1'b1);
    u_pin_host.load(16'hA5F0, RW, 3, 1'b0);
    check_load(16'hA5F0);
  endtask
  task automatic t_core_load();
    start(1'b0);
    u_core_host.load(16'h1230, RW, 3, 1'b0);
    check_load(16'h1230);
  endtask
  task automatic t_drop_fault();
    start(1'b0);
    u_core_host.load(16'h0F00, RW, 3, 1'b1);
    chk("drop fault", 16'h1, 16'(fault_seen));
  endtask
  task automatic t_cell_fault();
    start(1'b0);
    fork
      u_core_host.load(16'h7770, RW, 3, 1'b0);
      begin
        for (i = 0; i < 3000 && !cell_we; i++) @(posedge core_clk);
        #1 cell_fault = 1'b1;
      end
    join
    cell_fault = 1'b0;
    chk("cell fault", 16'h1, 16'(fault_seen));
  endtask
  task automatic t_restart();
    start(1'b0);
    u_core_host.load(16'h4440, RW, 12, 1'b0);
    chk("rearm", 16'h1, 16'(core_rearm));
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    host_source_select = 1'b0;
    cell_fault = 1'b0;
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    t_pin_load();
    t_core_load();
    t_drop_fault();
    t_cell_fault();
    t_restart();
    report_and_stop();
  end
endmodule
`default_nettype wire
